// file: ptg_pkg.sv
// Purpose: Constants and types for the test pattern frame setup block
// Assumes: One clock, asynchronous active-low reset
// Notes: Indirect page 0 holds the pattern generator settings
// Summary of operation
// - Virtual channel bits 7:6 of packet identity go into every emitted packet.
// - Data type bits 5:0 go into emitted packets; reset code 0x24 (RGB888).
// - Active line length in bytes is 16 bits; resets to 0x07 high, 0x80 low.
// - All bars but the last span bar width bytes; resets 0x00 high, 0xF0 low.
// - Last colour bar fills the remaining bytes up to the active line length.
// - Active lines per frame come from a 16-bit setting; reset value is 480.
// - Total lines per frame include blanking; low byte resets to 0x0D.
// - Each 16-bit setting keeps its high byte at the lower offset.
// - Frames are produced only while the enable bit 0 of control is set.
// - Fixed-pattern select bit 7 clear gives colour bars, set gives fixed pattern.
// - Registers reached through block select, offset and data; auto-increment advances offset.
package ptg_pkg;

	// Main register space window
	localparam logic [7:0] MAIN_BLOCK_SELECT = 8'hb0;
	localparam logic [7:0] MAIN_OFFSET = 8'hb1;
	localparam logic [7:0] MAIN_DATA_PORT = 8'hb2;
	localparam int SEL_AUTO_INC_BIT = 1;
	localparam int SEL_PAGE_MSB = 5;
	localparam int SEL_PAGE_LSB = 2;
	localparam logic [3:0] PAGE_PATTERN = 4'h0;
	localparam logic [7:0] BLOCK_SELECT_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h00;

	// Indirect page 0 offsets
	localparam logic [7:0] IND_CONTROL = 8'h01;
	localparam logic [7:0] IND_CONFIG = 8'h02;
	localparam logic [7:0] IND_PACKET_IDENTITY = 8'h03;
	localparam logic [7:0] IND_LINE_LENGTH_HIGH = 8'h04;
	localparam logic [7:0] IND_LINE_LENGTH_LOW = 8'h05;
	localparam logic [7:0] IND_BAR_WIDTH_HIGH = 8'h06;
	localparam logic [7:0] IND_BAR_WIDTH_LOW = 8'h07;
	localparam logic [7:0] IND_ACTIVE_LINES_HIGH = 8'h08;
	localparam logic [7:0] IND_ACTIVE_LINES_LOW = 8'h09;
	localparam logic [7:0] IND_TOTAL_LINES_HIGH = 8'h0a;
	localparam logic [7:0] IND_TOTAL_LINES_LOW = 8'h0b;

	// Field positions
	localparam int GEN_ON_BIT = 0;
	localparam int FIXED_SELECT_BIT = 7;
	localparam int BAR_CODE_MSB = 5;
	localparam int BAR_CODE_LSB = 4;
	localparam int BLOCK_SIZE_MSB = 3;
	localparam int BLOCK_SIZE_LSB = 0;
	localparam int VC_MSB = 7;
	localparam int VC_LSB = 6;
	localparam int DT_MSB = 5;
	localparam int DT_LSB = 0;

	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h33;
	localparam logic [7:0] PACKET_IDENTITY_RESET = 8'h24;
	localparam logic [7:0] LINE_LENGTH_HIGH_RESET = 8'h07;
	localparam logic [7:0] LINE_LENGTH_LOW_RESET = 8'h80;
	localparam logic [7:0] BAR_WIDTH_HIGH_RESET = 8'h00;
	localparam logic [7:0] BAR_WIDTH_LOW_RESET = 8'hf0;
	localparam logic [7:0] ACTIVE_LINES_HIGH_RESET = 8'h01;
	localparam logic [7:0] ACTIVE_LINES_LOW_RESET = 8'he0;
	localparam logic [7:0] TOTAL_LINES_HIGH_RESET = 8'h02;
	localparam logic [7:0] TOTAL_LINES_LOW_RESET = 8'h0d;

	// Counter constants
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		PTG_IDLE = 2'b00,
		PTG_ACTIVE = 2'b01,
		PTG_BLANK = 2'b10
	} ptg_state_t;

endpackage

// file: ptg_cfg_if.sv
// Purpose: Settings carried from the register window to the frame timer
// Assumes: All fields are register outputs of the window
// Notes: None
`timescale 1ns/1ps
interface ptg_cfg_if;
	logic generator_on;
	logic fixed_pattern_select;
	logic [1:0] bar_count_code;
	logic [3:0] block_size;
	logic [15:0] active_line_bytes;
	logic [15:0] bar_width_bytes;
	logic [15:0] active_lines_per_frame;
	logic [15:0] total_lines_per_frame;

	modport regs (
		output generator_on, fixed_pattern_select, bar_count_code, block_size,
		output active_line_bytes, bar_width_bytes, active_lines_per_frame, total_lines_per_frame
	);
	modport timer (
		input generator_on, fixed_pattern_select, bar_count_code, block_size,
		input active_line_bytes, bar_width_bytes, active_lines_per_frame, total_lines_per_frame
	);
endinterface

// file: ptg_frame_timer.sv
// Purpose: Line, bar and frame counting for the pattern stream
// Assumes: Settings are stable while a frame runs
// Notes: Zero line length, active line count and block size are treated as one
`timescale 1ns/1ps
module ptg_frame_timer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Settings
	ptg_cfg_if.timer cfg,
	// Stream to transmit path
	input wire logic pix_ready_i,
	output logic pix_valid_o,
	output logic [3:0] pix_sel_o,
	output logic line_start_o,
	output logic line_end_o,
	output logic frame_start_o,
	output logic frame_end_o,
	output logic busy_o
);

	function automatic logic [15:0] at_least_one(input logic [15:0] v);
		at_least_one = (v == ptg_pkg::COUNT_ZERO) ? ptg_pkg::COUNT_ONE : v;
	endfunction

	function automatic logic [2:0] last_bar(input logic [1:0] code);
		case (code)
			2'b00: last_bar = 3'd0;
			2'b01: last_bar = 3'd1;
			2'b10: last_bar = 3'd3;
			default: last_bar = 3'd7;
		endcase
	endfunction

	ptg_pkg::ptg_state_t state_q, state_d;
	logic [15:0] byte_q, byte_d;
	logic [15:0] line_q, line_d;
	logic [15:0] bar_fill_q, bar_fill_d;
	logic [2:0] bar_q, bar_d;
	logic [3:0] blk_q, blk_d;
	logic [3:0] sel_q, sel_d;
	logic frame_end_q, frame_end_d;
	logic last_byte;
	logic [15:0] line_next;
	logic [3:0] blk_last;

	assign last_byte = (byte_q == 16'(at_least_one(cfg.active_line_bytes) - ptg_pkg::COUNT_ONE));
	assign line_next = 16'(line_q + ptg_pkg::COUNT_ONE);
	assign blk_last = (cfg.block_size == 4'h0) ? 4'h0 : 4'(cfg.block_size - 4'h1);

	always_comb begin
		state_d = state_q;
		byte_d = byte_q;
		line_d = line_q;
		bar_fill_d = bar_fill_q;
		bar_d = bar_q;
		blk_d = blk_q;
		frame_end_d = 1'b0;
		case (state_q)
			ptg_pkg::PTG_IDLE: begin
				byte_d = ptg_pkg::COUNT_ZERO;
				line_d = ptg_pkg::COUNT_ZERO;
				bar_fill_d = ptg_pkg::COUNT_ZERO;
				bar_d = 3'd0;
				blk_d = 4'h0;
				if (cfg.generator_on) begin
					state_d = ptg_pkg::PTG_ACTIVE;
				end
			end
			ptg_pkg::PTG_ACTIVE: begin
				if (!cfg.generator_on) begin
					state_d = ptg_pkg::PTG_IDLE;
				end else if (pix_ready_i) begin
					if (last_byte) begin
						byte_d = ptg_pkg::COUNT_ZERO;
						bar_fill_d = ptg_pkg::COUNT_ZERO;
						bar_d = 3'd0;
						blk_d = 4'h0;
						if (line_next >= at_least_one(cfg.active_lines_per_frame)) begin
							if (cfg.total_lines_per_frame > line_next) begin
								state_d = ptg_pkg::PTG_BLANK;
								line_d = line_next;
							end else begin
								line_d = ptg_pkg::COUNT_ZERO;
								frame_end_d = 1'b1;
							end
						end else begin
							line_d = line_next;
						end
					end else begin
						byte_d = 16'(byte_q + ptg_pkg::COUNT_ONE);
						// Last bar keeps counting to line end
						if (bar_fill_q == 16'(cfg.bar_width_bytes - ptg_pkg::COUNT_ONE) &&
							bar_q != last_bar(cfg.bar_count_code)) begin
							bar_d = 3'(bar_q + 3'd1);
							bar_fill_d = ptg_pkg::COUNT_ZERO;
						end else begin
							bar_fill_d = 16'(bar_fill_q + ptg_pkg::COUNT_ONE);
						end
						blk_d = (blk_q >= blk_last) ? 4'h0 : 4'(blk_q + 4'h1);
					end
				end
			end
			ptg_pkg::PTG_BLANK: begin
				if (!cfg.generator_on) begin
					state_d = ptg_pkg::PTG_IDLE;
				end else if (last_byte) begin
					byte_d = ptg_pkg::COUNT_ZERO;
					if (line_next >= cfg.total_lines_per_frame) begin
						line_d = ptg_pkg::COUNT_ZERO;
						frame_end_d = 1'b1;
						state_d = ptg_pkg::PTG_ACTIVE;
					end else begin
						line_d = line_next;
					end
				end else begin
					byte_d = 16'(byte_q + ptg_pkg::COUNT_ONE);
				end
			end
			default: begin
				state_d = ptg_pkg::PTG_IDLE;
			end
		endcase
		sel_d = cfg.fixed_pattern_select ? blk_d : {1'b0, bar_d};
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ptg_pkg::PTG_IDLE;
			byte_q <= ptg_pkg::COUNT_ZERO;
			line_q <= ptg_pkg::COUNT_ZERO;
			bar_fill_q <= ptg_pkg::COUNT_ZERO;
			bar_q <= 3'd0;
			blk_q <= 4'h0;
			sel_q <= 4'h0;
			frame_end_q <= 1'b0;
		end else begin
			state_q <= state_d;
			byte_q <= byte_d;
			line_q <= line_d;
			bar_fill_q <= bar_fill_d;
			bar_q <= bar_d;
			blk_q <= blk_d;
			sel_q <= sel_d;
			frame_end_q <= frame_end_d;
		end
	end

	assign pix_valid_o = (state_q == ptg_pkg::PTG_ACTIVE) && cfg.generator_on;
	assign pix_sel_o = sel_q;
	assign line_start_o = pix_valid_o && (byte_q == ptg_pkg::COUNT_ZERO);
	assign line_end_o = pix_valid_o && last_byte;
	assign frame_start_o = line_start_o && (line_q == ptg_pkg::COUNT_ZERO);
	assign frame_end_o = frame_end_q;
	assign busy_o = (state_q != ptg_pkg::PTG_IDLE);

endmodule

// file: ptg_top.sv
// Purpose: Indirect register window and frame setup for the test pattern generator
// Assumes: Main register accesses arrive as one-cycle strobes from the control port
// Notes: Read data appear one cycle after the read strobe
`timescale 1ns/1ps
module ptg_top (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Main register space access
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Packet identity to transmit path
	output logic [1:0] virtual_channel_o,
	output logic [5:0] data_type_o,
	// Pattern stream to transmit path
	input wire logic pix_ready_i,
	output logic pix_valid_o,
	output logic [3:0] pix_sel_o,
	output logic fixed_pattern_o,
	output logic line_start_o,
	output logic line_end_o,
	output logic frame_start_o,
	output logic frame_end_o,
	output logic busy_o
);

	ptg_cfg_if cfg_bus ();

	logic [7:0] block_sel_q, block_sel_d;
	logic [7:0] offset_q, offset_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] control_q, control_d;
	logic [7:0] config_q, config_d;
	logic [7:0] identity_q, identity_d;
	logic [7:0] line_hi_q, line_hi_d;
	logic [7:0] line_lo_q, line_lo_d;
	logic [7:0] bar_hi_q, bar_hi_d;
	logic [7:0] bar_lo_q, bar_lo_d;
	logic [7:0] act_hi_q, act_hi_d;
	logic [7:0] act_lo_q, act_lo_d;
	logic [7:0] tot_hi_q, tot_hi_d;
	logic [7:0] tot_lo_q, tot_lo_d;
	logic page_hit;
	logic data_wr;
	logic data_rd;
	logic [7:0] ind_rdata;

	assign page_hit = (block_sel_q[ptg_pkg::SEL_PAGE_MSB:ptg_pkg::SEL_PAGE_LSB] == ptg_pkg::PAGE_PATTERN);
	assign data_wr = reg_wr_i && (reg_addr_i == ptg_pkg::MAIN_DATA_PORT);
	assign data_rd = reg_rd_i && !reg_wr_i && (reg_addr_i == ptg_pkg::MAIN_DATA_PORT);

	// Indirect read mux, high byte at lower offset
	always_comb begin
		ind_rdata = 8'h00;
		if (page_hit) begin
			case (offset_q)
				ptg_pkg::IND_CONTROL: ind_rdata = control_q;
				ptg_pkg::IND_CONFIG: ind_rdata = config_q;
				ptg_pkg::IND_PACKET_IDENTITY: ind_rdata = identity_q;
				ptg_pkg::IND_LINE_LENGTH_HIGH: ind_rdata = line_hi_q;
				ptg_pkg::IND_LINE_LENGTH_LOW: ind_rdata = line_lo_q;
				ptg_pkg::IND_BAR_WIDTH_HIGH: ind_rdata = bar_hi_q;
				ptg_pkg::IND_BAR_WIDTH_LOW: ind_rdata = bar_lo_q;
				ptg_pkg::IND_ACTIVE_LINES_HIGH: ind_rdata = act_hi_q;
				ptg_pkg::IND_ACTIVE_LINES_LOW: ind_rdata = act_lo_q;
				ptg_pkg::IND_TOTAL_LINES_HIGH: ind_rdata = tot_hi_q;
				ptg_pkg::IND_TOTAL_LINES_LOW: ind_rdata = tot_lo_q;
				default: ind_rdata = 8'h00;
			endcase
		end
	end

	// Window and indirect register next values
	always_comb begin
		block_sel_d = block_sel_q;
		offset_d = offset_q;
		rdata_d = rdata_q;
		control_d = control_q;
		config_d = config_q;
		identity_d = identity_q;
		line_hi_d = line_hi_q;
		line_lo_d = line_lo_q;
		bar_hi_d = bar_hi_q;
		bar_lo_d = bar_lo_q;
		act_hi_d = act_hi_q;
		act_lo_d = act_lo_q;
		tot_hi_d = tot_hi_q;
		tot_lo_d = tot_lo_q;
		if (reg_wr_i && reg_addr_i == ptg_pkg::MAIN_BLOCK_SELECT) begin
			block_sel_d = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == ptg_pkg::MAIN_OFFSET) begin
			offset_d = reg_wdata_i;
		end
		if (data_wr && page_hit) begin
			case (offset_q)
				ptg_pkg::IND_CONTROL: control_d = reg_wdata_i;
				ptg_pkg::IND_CONFIG: config_d = reg_wdata_i;
				ptg_pkg::IND_PACKET_IDENTITY: identity_d = reg_wdata_i;
				ptg_pkg::IND_LINE_LENGTH_HIGH: line_hi_d = reg_wdata_i;
				ptg_pkg::IND_LINE_LENGTH_LOW: line_lo_d = reg_wdata_i;
				ptg_pkg::IND_BAR_WIDTH_HIGH: bar_hi_d = reg_wdata_i;
				ptg_pkg::IND_BAR_WIDTH_LOW: bar_lo_d = reg_wdata_i;
				ptg_pkg::IND_ACTIVE_LINES_HIGH: act_hi_d = reg_wdata_i;
				ptg_pkg::IND_ACTIVE_LINES_LOW: act_lo_d = reg_wdata_i;
				ptg_pkg::IND_TOTAL_LINES_HIGH: tot_hi_d = reg_wdata_i;
				ptg_pkg::IND_TOTAL_LINES_LOW: tot_lo_d = reg_wdata_i;
				default: control_d = control_q;
			endcase
		end
		if ((data_wr || data_rd) && block_sel_q[ptg_pkg::SEL_AUTO_INC_BIT]) begin
			offset_d = 8'(offset_q + 8'h01);
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				ptg_pkg::MAIN_BLOCK_SELECT: rdata_d = block_sel_q;
				ptg_pkg::MAIN_OFFSET: rdata_d = offset_q;
				ptg_pkg::MAIN_DATA_PORT: rdata_d = ind_rdata;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			block_sel_q <= ptg_pkg::BLOCK_SELECT_RESET;
			offset_q <= ptg_pkg::OFFSET_RESET;
			rdata_q <= 8'h00;
			control_q <= ptg_pkg::CONTROL_RESET;
			config_q <= ptg_pkg::CONFIG_RESET;
			identity_q <= ptg_pkg::PACKET_IDENTITY_RESET;
			line_hi_q <= ptg_pkg::LINE_LENGTH_HIGH_RESET;
			line_lo_q <= ptg_pkg::LINE_LENGTH_LOW_RESET;
			bar_hi_q <= ptg_pkg::BAR_WIDTH_HIGH_RESET;
			bar_lo_q <= ptg_pkg::BAR_WIDTH_LOW_RESET;
			act_hi_q <= ptg_pkg::ACTIVE_LINES_HIGH_RESET;
			act_lo_q <= ptg_pkg::ACTIVE_LINES_LOW_RESET;
			tot_hi_q <= ptg_pkg::TOTAL_LINES_HIGH_RESET;
			tot_lo_q <= ptg_pkg::TOTAL_LINES_LOW_RESET;
		end else begin
			block_sel_q <= block_sel_d;
			offset_q <= offset_d;
			rdata_q <= rdata_d;
			control_q <= control_d;
			config_q <= config_d;
			identity_q <= identity_d;
			line_hi_q <= line_hi_d;
			line_lo_q <= line_lo_d;
			bar_hi_q <= bar_hi_d;
			bar_lo_q <= bar_lo_d;
			act_hi_q <= act_hi_d;
			act_lo_q <= act_lo_d;
			tot_hi_q <= tot_hi_d;
			tot_lo_q <= tot_lo_d;
		end
	end

	// Settings to the timer
	assign cfg_bus.generator_on = control_q[ptg_pkg::GEN_ON_BIT];
	assign cfg_bus.fixed_pattern_select = config_q[ptg_pkg::FIXED_SELECT_BIT];
	assign cfg_bus.bar_count_code = config_q[ptg_pkg::BAR_CODE_MSB:ptg_pkg::BAR_CODE_LSB];
	assign cfg_bus.block_size = config_q[ptg_pkg::BLOCK_SIZE_MSB:ptg_pkg::BLOCK_SIZE_LSB];
	assign cfg_bus.active_line_bytes = {line_hi_q, line_lo_q};
	assign cfg_bus.bar_width_bytes = {bar_hi_q, bar_lo_q};
	assign cfg_bus.active_lines_per_frame = {act_hi_q, act_lo_q};
	assign cfg_bus.total_lines_per_frame = {tot_hi_q, tot_lo_q};

	ptg_frame_timer u_timer (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.cfg(cfg_bus.timer),
		.pix_ready_i(pix_ready_i),
		.pix_valid_o(pix_valid_o),
		.pix_sel_o(pix_sel_o),
		.line_start_o(line_start_o),
		.line_end_o(line_end_o),
		.frame_start_o(frame_start_o),
		.frame_end_o(frame_end_o),
		.busy_o(busy_o)
	);

	assign reg_rdata_o = rdata_q;
	assign virtual_channel_o = identity_q[ptg_pkg::VC_MSB:ptg_pkg::VC_LSB];
	assign data_type_o = identity_q[ptg_pkg::DT_MSB:ptg_pkg::DT_LSB];
	assign fixed_pattern_o = config_q[ptg_pkg::FIXED_SELECT_BIT];

endmodule

// file: ptg_top_props.sv
// Purpose: Port assertions for the pattern frame setup block
// Assumes: Single clock domain, reset active low
// Notes: Bound to ptg_top below
`timescale 1ns/1ps
module ptg_top_props (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Stream
	input wire logic pix_ready_i,
	input wire logic pix_valid_o,
	input wire logic [3:0] pix_sel_o,
	input wire logic fixed_pattern_o,
	input wire logic line_start_o,
	input wire logic frame_start_o,
	input wire logic busy_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	property p_stall_hold;
		pix_valid_o && !pix_ready_i && !reg_wr_i |=> pix_valid_o && $stable(pix_sel_o);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stream moved during stall");
	property p_line_first;
		line_start_o |-> pix_valid_o && pix_sel_o == 4'h0;
	endproperty
	a_line_first: assert property (p_line_first) else $error("line not starting at index 0");
	property p_frame_first;
		frame_start_o |-> line_start_o;
	endproperty
	a_frame_first: assert property (p_frame_first) else $error("frame start off line start");
	property p_bar_range;
		pix_valid_o && !fixed_pattern_o |-> pix_sel_o < 4'h8;
	endproperty
	a_bar_range: assert property (p_bar_range) else $error("bar index above seven");
	property p_bar_step;
		pix_valid_o && pix_ready_i && !line_start_o && !fixed_pattern_o && !reg_wr_i
		|-> pix_sel_o == $past(pix_sel_o) || pix_sel_o == $past(pix_sel_o) + 4'h1;
	endproperty
	a_bar_step: assert property (p_bar_step) else $error("bar index jumped");
	property p_unmapped_zero;
		reg_rd_i && !(reg_addr_i inside {8'hb0, 8'hb1, 8'hb2}) |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	property p_rdata_hold;
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
	property p_select_back;
		reg_wr_i && reg_addr_i == 8'hb0 ##1 !(reg_wr_i && reg_addr_i == 8'hb0)
		##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'hb0
		|=> reg_rdata_o == $past(reg_wdata_i, 3);
	endproperty
	a_select_back: assert property (p_select_back) else $error("block select readback wrong");
	property p_idle_quiet;
		!busy_o |-> !pix_valid_o;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("valid while idle");
endmodule
bind ptg_top ptg_top_props u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.pix_ready_i(pix_ready_i), .pix_valid_o(pix_valid_o), .pix_sel_o(pix_sel_o),
	.fixed_pattern_o(fixed_pattern_o), .line_start_o(line_start_o), .frame_start_o(frame_start_o),
	.busy_o(busy_o));

// file: ptg_tx_model.sv
// Purpose: Transmit path stand-in that accepts pattern bytes
// Assumes: Ready may drop on any cycle
// Notes: Stalls about one cycle in four
`timescale 1ns/1ps
module ptg_tx_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Stream handshake
	output logic pix_ready_o
);
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pix_ready_o <= 1'b0;
		end else begin
			pix_ready_o <= ($urandom_range(3) != 0);
		end
	end
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the pattern frame setup block
// Assumes: Partner model drives the ready input
// Notes: Random geometry from a fixed seed
`timescale 1ns/1ps
module tb_top;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic pix_ready_i;
	logic [7:0] reg_rdata_o, rv, id;
	logic [1:0] virtual_channel_o;
	logic [5:0] data_type_o;
	logic [3:0] pix_sel_o;
	logic pix_valid_o, fixed_pattern_o, line_start_o, line_end_o, frame_start_o, frame_end_o, busy_o;
	logic fixed;
	logic mon_on = 1'b0;
	logic [7:0] geo [8];
	logic [7:0] rst_tab [11] = '{8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hf0, 8'h01, 8'he0, 8'h02, 8'h0d};
	int failures = 0;
	int check_count = 0;
	int ll, bw, al, tl, code, blk, pos, ln, bytes, blank, frames;

	always #2 mclk_i = ~mclk_i;

	ptg_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.virtual_channel_o(virtual_channel_o), .data_type_o(data_type_o), .pix_ready_i(pix_ready_i),
		.pix_valid_o(pix_valid_o), .pix_sel_o(pix_sel_o), .fixed_pattern_o(fixed_pattern_o),
		.line_start_o(line_start_o), .line_end_o(line_end_o), .frame_start_o(frame_start_o),
		.frame_end_o(frame_end_o), .busy_o(busy_o));
	ptg_tx_model u_tx (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pix_ready_o(pix_ready_i));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= w;
		reg_rd_i <= !w;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		#1 rv = reg_rdata_o;
	endtask

	task automatic ind(input logic [7:0] off, input logic [7:0] d, input logic w);
		bus(8'hb0, 8'h02, 1'b1);
		bus(8'hb1, off, 1'b1);
		bus(8'hb2, d, w);
	endtask

	task automatic report_and_stop;
		if (failures == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	function automatic logic [3:0] exp_sel(input int p);
		int n;
		n = 1 << code;
		if (fixed) begin
			return 4'(p % ((blk == 0) ? 1 : blk));
		end
		return 4'((p / bw > n - 1) ? n - 1 : p / bw);
	endfunction

	// Stream monitor with expected bar, line and frame positions
	always @(posedge mclk_i) begin
		if (!mon_on) begin
			pos = 0;
			ln = 0;
			bytes = 0;
			blank = 0;
			frames = 0;
		end else begin
			if (frame_end_o === 1'b1) begin
				chk("frame bytes", 16'(bytes), 16'(al * ll));
				chk("blank cycles", 16'(blank), 16'((tl - al) * ll));
				bytes = 0;
				blank = 0;
				ln = 0;
				frames++;
			end
			if (busy_o === 1'b1 && pix_valid_o === 1'b0) blank++;
			if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
				chk("bar index", 16'(pix_sel_o), 16'(exp_sel(pos)));
				chk("line start", 16'(line_start_o), 16'(pos == 0));
				chk("line end", 16'(line_end_o), 16'(pos == ll - 1));
				chk("frame start", 16'(frame_start_o), 16'(pos == 0 && ln == 0));
				bytes++;
				pos = (pos == ll - 1) ? 0 : pos + 1;
				if (pos == 0) ln++;
			end
		end
	end

	initial begin
		#100000;
		failures++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hcb02_e94d));
		repeat (20) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		#1;
		chk("type at reset", 16'(data_type_o), 16'h0024);
		bus(8'hb0, 8'h02, 1'b1);
		bus(8'hb0, 8'h00, 1'b0);
		chk("block select", 16'(rv), 16'h0002);
		bus(8'hb1, 8'h01, 1'b1);
		for (int i = 0; i < 11; i++) begin
			bus(8'hb2, 8'h00, 1'b0);
			chk("reset value", 16'(rv), 16'(rst_tab[i]));
		end
		bus(8'hb2, 8'h00, 1'b0);
		chk("unused offset", 16'(rv), 16'h0000);
		bus(8'ha5, 8'h5a, 1'b1);
		bus(8'ha5, 8'h00, 1'b0);
		chk("unmapped", 16'(rv), 16'h0000);
		bus(8'hb0, 8'h00, 1'b1);
		bus(8'hb1, 8'h03, 1'b1);
		for (int i = 0; i < 2; i++) begin
			bus(8'hb2, 8'h00, 1'b0);
			chk("held offset", 16'(rv), 16'h0024);
		end
		bus(8'hb1, 8'h00, 1'b0);
		chk("offset kept", 16'(rv), 16'h0003);
		bus(8'hb0, 8'h04, 1'b1);
		bus(8'hb2, 8'h00, 1'b0);
		chk("other page", 16'(rv), 16'h0000);
		for (int k = 0; k < 5; k++) begin
			code = k % 4;
			fixed = (k == 4);
			blk = $urandom_range(15);
			ll = $urandom_range(20, 3);
			bw = $urandom_range(6, 1);
			al = 2;
			tl = $urandom_range(4, 3);
			id = 8'($urandom);
			geo = '{8'h00, 8'(ll), 8'h00, 8'(bw), 8'h00, 8'(al), 8'h00, 8'(tl)};
			ind(8'h02, {fixed, 1'b0, 2'(code), 4'(blk)}, 1'b1);
			bus(8'hb2, id, 1'b1);
			for (int j = 0; j < 8; j++) bus(8'hb2, geo[j], 1'b1);
			chk("channel", 16'(virtual_channel_o), 16'(id[7:6]));
			chk("data type", 16'(data_type_o), 16'(id[5:0]));
			chk("fixed flag", 16'(fixed_pattern_o), 16'(fixed));
			ind(8'h04, 8'h00, 1'b0);
			chk("line high", 16'(rv), 16'h0000);
			bus(8'hb2, 8'h00, 1'b0);
			chk("line low", 16'(rv), 16'(ll));
			mon_on <= 1'b1;
			ind(8'h01, 8'h01, 1'b1);
			for (int t = 0; t < 3000 && frames < 2; t++) @(posedge mclk_i);
			#1;
			chk("frames", 16'(frames), 16'h0002);
			ind(8'h01, 8'h00, 1'b1);
			mon_on <= 1'b0;
			@(posedge mclk_i);
			#1;
			chk("valid off", 16'(pix_valid_o), 16'h0000);
			chk("busy off", 16'(busy_o), 16'h0000);
		end
		@(posedge mclk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		#1;
		chk("type after reset", 16'(data_type_o), 16'h0024);
		chk("channel after reset", 16'(virtual_channel_o), 16'h0000);
		chk("fixed after reset", 16'(fixed_pattern_o), 16'h0000);
		bus(8'hb0, 8'h02, 1'b1);
		bus(8'hb1, 8'h04, 1'b1);
		bus(8'hb2, 8'h00, 1'b0);
		chk("line high after reset", 16'(rv), 16'h0007);
		bus(8'hb2, 8'h00, 1'b0);
		chk("line low after reset", 16'(rv), 16'h0080);
		report_and_stop();
	end
endmodule
